// ==== pio_pad_model.sv ====
/* Pad model: resolves each pin wire from the block and an outside driver.
   Assumes the bench sets ext_en and ext_val for the outside driver. */
module pio_pad_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Floating pin shows the inverse, so no stale level passes unnoticed
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pullup | ~pin_out));
endmodule

// ==== pio_pin_ctrl.sv ====
/*
 * Parallel I/O pin control for one 8-bit port: output latch, direction,
 * peripheral and analog override, pull-up, slew and drive controls.
 * Assumes pads outside resolve the wire from pin_out/pin_oe and that
 * peripheral enables and outputs come from logic on clk_sys.
 */
// Behaviour
// RL1 - An enabled shared peripheral takes the pin from general-purpose I/O
// RL2 - Reset disables peripheral functions and clears all direction bits; periph_en is not reset here and takes the pins again when reset ends
// RL3 - Reset sets slew limit, clears high drive and pull-up enable
// RL4 - Direction bit enables output buffer and picks data read source
// RL5 - Input buffer stays on unless analog function or output-only pin
// RL6 - Shared digital function drives output enable instead of direction
// RL7 - Direction bit still picks data read source under a peripheral
// RL8 - Analog function disables input and output buffers of the pin
// RL9 - Input-direction read returns 0 when the input buffer is off
// RL10 - Analog function wins over digital function on the same pin
// RL11 - Software should load the data latch before making pins outputs
// RL12 - One pull-up enable bit per pin turns on its pull-up
// RL13 - Pull-up off whenever the pin drives, by direction or peripheral
// RL14 - Pull-up off whenever an analog function controls the pin
// RL15 - Per-pin slew limit bit, no effect on input pins
// RL16 - Per-pin drive select bit chooses high output drive
// RL17 - Pin control registers live apart from data and direction
// RL18 - Data writes latch all bits; output pins drive the latch
// RL19 - Read gives pin level for inputs, latched bit for outputs
// RL20 - Reset clears the latch without driving it out
// RL21 - Control latches update on the bus clock, reset to defaults
module pio_pin_ctrl
    import pio_pkg::*;
#(
    parameter int WIDTH = PIO_WIDTH,
    parameter logic [WIDTH-1:0] OUTPUT_ONLY = '0
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [PIO_ADDR_W-1:0] reg_addr,
    input wire logic [WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [WIDTH-1:0] reg_rdata,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pin_ibe,
    output logic [WIDTH-1:0] pin_pullup,
    output logic [WIDTH-1:0] pin_slew,
    output logic [WIDTH-1:0] pin_high_drive,
    input wire logic [WIDTH-1:0] periph_en,
    input wire logic [WIDTH-1:0] periph_out,
    input wire logic [WIDTH-1:0] periph_oe,
    input wire logic [WIDTH-1:0] analog_en,
    output logic [WIDTH-1:0] periph_in
);

    function automatic logic hit(input logic [PIO_ADDR_W-1:0] a,
                                 input logic [PIO_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic [WIDTH-1:0] port_output_latch_ff, nxt_port_output_latch;
    logic [WIDTH-1:0] pin_direction_bit_ff, nxt_pin_direction_bit;
    logic [WIDTH-1:0] pullup_enable_bit_ff, nxt_pullup_enable_bit;
    logic [WIDTH-1:0] slew_limit_enable_bit_ff, nxt_slew_limit_enable_bit;
    logic [WIDTH-1:0] high_drive_select_bit_ff, nxt_high_drive_select_bit;
    logic [WIDTH-1:0] pin_s1_ff, pin_s2_ff;
    logic [WIDTH-1:0] rdata_ff, nxt_rdata;
    logic [WIDTH-1:0] out_ff, nxt_out;
    logic [WIDTH-1:0] oe_ff, nxt_oe;
    logic [WIDTH-1:0] ibe_ff, nxt_ibe;
    logic [WIDTH-1:0] pu_ff, nxt_pu;
    logic [WIDTH-1:0] slew_ff, nxt_slew;
    logic [WIDTH-1:0] hd_ff, nxt_hd;
    logic [WIDTH-1:0] pin_rd_ff, nxt_pin_rd;
    logic [WIDTH-1:0] in_buf;
    logic [WIDTH-1:0] data_view;

    // Register writes
    always_comb begin
        nxt_port_output_latch = port_output_latch_ff;
        nxt_pin_direction_bit = pin_direction_bit_ff;
        nxt_pullup_enable_bit = pullup_enable_bit_ff;
        nxt_slew_limit_enable_bit = slew_limit_enable_bit_ff;
        nxt_high_drive_select_bit = high_drive_select_bit_ff;
        if (reg_wr) begin
            // RL18 RL11 latch all bits
            if (hit(reg_addr, PIO_OFF_DATA)) begin
                nxt_port_output_latch = reg_wdata;
            end
            if (hit(reg_addr, PIO_OFF_DIR)) begin
                nxt_pin_direction_bit = reg_wdata;
            end
            // RL17 RL12 separate control space
            if (hit(reg_addr, PIO_OFF_PULLUP)) begin
                nxt_pullup_enable_bit = reg_wdata;
            end
            // RL15 slew bit write
            if (hit(reg_addr, PIO_OFF_SLEW)) begin
                nxt_slew_limit_enable_bit = reg_wdata;
            end
            // RL16 drive bit write
            if (hit(reg_addr, PIO_OFF_DRIVE)) begin
                nxt_high_drive_select_bit = reg_wdata;
            end
        end
    end

    // RL21 RL2 RL3 RL20 synchronous reset defaults
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            port_output_latch_ff <= PIO_RST_DATA;
            pin_direction_bit_ff <= PIO_RST_DIR;
            pullup_enable_bit_ff <= PIO_RST_PULLUP;
            slew_limit_enable_bit_ff <= PIO_RST_SLEW;
            high_drive_select_bit_ff <= PIO_RST_DRIVE;
        end else begin
            port_output_latch_ff <= nxt_port_output_latch;
            pin_direction_bit_ff <= nxt_pin_direction_bit;
            pullup_enable_bit_ff <= nxt_pullup_enable_bit;
            slew_limit_enable_bit_ff <= nxt_slew_limit_enable_bit;
            high_drive_select_bit_ff <= nxt_high_drive_select_bit;
        end
    end

    // Pins are asynchronous to the bus clock
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pin_s1_ff <= PIO_ZERO;
            pin_s2_ff <= PIO_ZERO;
        end else begin
            pin_s1_ff <= pin_in;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // Combinational input buffer, seen only through the second stage
    always_comb begin
        // RL5 RL8 input buffer enable
        in_buf = ~(analog_en | OUTPUT_ONLY);
    end

    // Per-pin pad control
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            logic ana;
            logic dig;
            logic drv;
            // RL10 analog wins over digital
            assign ana = analog_en[g];
            // RL1 peripheral takes the pin
            assign dig = periph_en[g] & ~ana;
            // RL4 RL6 output enable source
            assign drv = ana ? 1'b0 :
                         dig ? periph_oe[g] : pin_direction_bit_ff[g];
            always_comb begin
                nxt_oe[g] = drv;
                nxt_out[g] = dig ? periph_out[g] : port_output_latch_ff[g];
                nxt_ibe[g] = in_buf[g];
                // RL13 RL14 pull-up overrides
                nxt_pu[g] = pullup_enable_bit_ff[g] & ~drv & ~ana;
                // RL15 no slew effect on inputs
                nxt_slew[g] = slew_limit_enable_bit_ff[g] & drv;
                // RL16 high drive select
                nxt_hd[g] = high_drive_select_bit_ff[g] & drv;
                // RL9 buffer off reads zero
                nxt_pin_rd[g] = pin_s2_ff[g] & in_buf[g];
            end
        end
    endgenerate

    always_comb begin
        // RL19 RL7 read source by direction
        data_view = (pin_direction_bit_ff & port_output_latch_ff) |
                    (~pin_direction_bit_ff & pin_rd_ff);
        nxt_rdata = PIO_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                PIO_OFF_DATA: nxt_rdata = data_view;
                PIO_OFF_DIR: nxt_rdata = pin_direction_bit_ff;
                PIO_OFF_PULLUP: nxt_rdata = pullup_enable_bit_ff;
                PIO_OFF_SLEW: nxt_rdata = slew_limit_enable_bit_ff;
                PIO_OFF_DRIVE: nxt_rdata = high_drive_select_bit_ff;
                PIO_OFF_STATUS: nxt_rdata = oe_ff;
                default: nxt_rdata = PIO_ZERO;
            endcase
        end
    end

    // Pad outputs registered so the pads see no decode glitches
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata_ff <= PIO_ZERO;
            out_ff <= PIO_ZERO;
            oe_ff <= PIO_ZERO;
            ibe_ff <= PIO_ZERO;
            pu_ff <= PIO_ZERO;
            slew_ff <= PIO_ZERO;
            hd_ff <= PIO_ZERO;
            pin_rd_ff <= PIO_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            ibe_ff <= nxt_ibe;
            pu_ff <= nxt_pu;
            slew_ff <= nxt_slew;
            hd_ff <= nxt_hd;
            pin_rd_ff <= nxt_pin_rd;
        end
    end

    assign reg_rdata = rdata_ff;
    assign pin_out = out_ff;
    assign pin_oe = oe_ff;
    assign pin_ibe = ibe_ff;
    assign pin_pullup = pu_ff;
    assign pin_slew = slew_ff;
    assign pin_high_drive = hd_ff;
    assign periph_in = pin_rd_ff;

endmodule

// ==== pio_pkg.sv ====
/*
 * Package for the parallel I/O pin control block: register offsets,
 * reset values and widths.
 * Assumes a plain register port with 8-bit data, one aligned word each.
 */
package pio_pkg;
    localparam int PIO_ADDR_W = 4;
    localparam int PIO_WIDTH = 8;
    // Data and direction space
    localparam logic [3:0] PIO_OFF_DATA = 4'h0;
    localparam logic [3:0] PIO_OFF_DIR = 4'h1;
    // Pin control space, separate from data and direction
    localparam logic [3:0] PIO_OFF_PULLUP = 4'h8;
    localparam logic [3:0] PIO_OFF_SLEW = 4'h9;
    localparam logic [3:0] PIO_OFF_DRIVE = 4'hA;
    // Read-only view of the output enables driven to the pads
    localparam logic [3:0] PIO_OFF_STATUS = 4'hC;
    localparam logic [7:0] PIO_RST_DATA = 8'h00;
    localparam logic [7:0] PIO_RST_DIR = 8'h00;
    localparam logic [7:0] PIO_RST_PULLUP = 8'h00;
    localparam logic [7:0] PIO_RST_SLEW = 8'hFF;
    localparam logic [7:0] PIO_RST_DRIVE = 8'h00;
    localparam logic [7:0] PIO_ZERO = 8'h00;
endpackage

// ==== pio_props.sv ====
/* Checker for the pin control block, bound to its top module.
   Assumes one clock domain with a synchronous active-low reset. */
module pio_props
    import pio_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [PIO_ADDR_W-1:0] reg_addr,
    input wire logic [PIO_WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [PIO_WIDTH-1:0] pin_oe,
    input wire logic [PIO_WIDTH-1:0] pin_ibe,
    input wire logic [PIO_WIDTH-1:0] pin_pullup,
    input wire logic [PIO_WIDTH-1:0] pin_slew,
    input wire logic [PIO_WIDTH-1:0] pin_high_drive,
    input wire logic [PIO_WIDTH-1:0] periph_en,
    input wire logic [PIO_WIDTH-1:0] periph_oe,
    input wire logic [PIO_WIDTH-1:0] analog_en
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence dir_wr;
        reg_wr && reg_addr == PIO_OFF_DIR;
    endsequence
    dir_oe_a: assert property (dir_wr |-> ##2
        ((pin_oe ^ $past(reg_wdata, 2)) & ~$past(periph_en | analog_en)) == 0)
        else $error("oe differs from direction");
    periph_oe_a: assert property ($past(rstn) |->
        ((pin_oe ^ $past(periph_oe)) & $past(periph_en & ~analog_en)) == 0)
        else $error("oe not from peripheral");
    analog_off_a: assert property ($past(rstn) |->
        ($past(analog_en) & (pin_oe | pin_ibe | pin_pullup)) == 0)
        else $error("analog pin buffers on");
    ibe_on_a: assert property (
        $past(rstn) |-> pin_ibe == ~$past(analog_en)) else $error("ibe");
    pullup_off_a: assert property (
        (pin_pullup & pin_oe) == 0) else $error("pull-up on output");
    slew_gate_a: assert property (
        (pin_slew & ~pin_oe) == 0) else $error("slew on input");
    drive_gate_a: assert property (
        (pin_high_drive & ~pin_oe) == 0) else $error("drive on input");
    reset_out_a: assert property ($rose(rstn) |->
        (pin_oe | pin_ibe | pin_pullup | pin_slew | pin_high_drive) == 0)
        else $error("pin active after reset");
endmodule
bind pio_pin_ctrl pio_props pio_props_inst (.*);

// ==== testbench.sv ====
/* Self-checking bench for the pin control block with a pad model.
   Assumes registers answer one cycle after the read strobe. */
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    n_errors++; $display("CHECK FAILED %0t mismatch", $time); end end
module testbench
    import pio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
    logic [3:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata, pin_in, pin_out, pin_oe, pin_ibe;
    logic [7:0] pin_pullup, pin_slew, pin_high_drive, periph_in;
    logic [7:0] periph_en = '0, periph_out = '0, periph_oe = '0;
    logic [7:0] analog_en = '0, ext_en = '0, ext_val = '0;
    logic [7:0] regs [16];
    logic [3:0] tbl [7] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hC, 4'h5};
    int n_errors = 0, comparisons = 0, seed = 32'h7f15;
    pio_pin_ctrl pio_pin_ctrl_inst (.*);
    pio_pad_model pio_pad_model_inst (.*);
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] rnd();
        return 8'($random(seed));
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        if (a inside {4'h0, 4'h1, 4'h8, 4'h9, 4'hA}) regs[a] = d;
    endtask
    task automatic check_all();
        logic [7:0] dg, oe, o, pu, w, m, e, r;
        repeat (4) @(posedge clk_sys);
        // Sample off the edge so the pad outputs have settled
        #1;
        dg = periph_en & ~analog_en;
        oe = (dg & periph_oe) | (~periph_en & ~analog_en & regs[1]);
        o = (dg & periph_out) | (~dg & regs[0]);
        pu = regs[8] & ~oe & ~analog_en;
        w = (oe & o) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pu);
        `CHK(pin_oe, oe)
        `CHK(pin_out & oe, o & oe)
        `CHK(pin_pullup, pu)
        `CHK(pin_slew, regs[9] & oe)
        `CHK(pin_high_drive, regs[10] & oe)
        `CHK(pin_ibe, ~analog_en)
        m = analog_en | oe | ext_en | pu;
        `CHK(periph_in & m, ~analog_en & w & m)
        foreach (tbl[i]) begin
            @(posedge clk_sys);
            reg_addr <= tbl[i];
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            #1 r = reg_rdata;
            e = (tbl[i] == 4'hC) ? oe : regs[tbl[i]];
            m = 8'hff;
            if (tbl[i] == 4'h0) begin
                e = (regs[1] & regs[0]) | (~regs[1] & ~analog_en & w);
                m = regs[1] | analog_en | oe | ext_en | pu;
            end
            `CHK(r & m, e & m)
        end
        // Read data stands one cycle only, zero afterwards
        @(posedge clk_sys);
        #1 `CHK(reg_rdata, 8'h00)
    endtask
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        regs = '{default: 8'h00};
        regs[9] = 8'hff;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        check_all();
        $display("reset test done");
        // latch loaded before pins turn to outputs
        wr(4'h0, 8'ha5);
        wr(4'h1, 8'hff);
        check_all();
        for (int i = 0; i < 60; i++) begin
            @(posedge clk_sys);
            periph_en <= rnd() & rnd();
            periph_out <= rnd();
            periph_oe <= rnd();
            analog_en <= rnd() & rnd();
            ext_en <= rnd();
            ext_val <= rnd();
            wr(tbl[rnd() % 7], rnd());
            check_all();
            $display("random test %0d done", i);
        end
        // second reset while peripherals stay active
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 `CHK(pin_oe | pin_pullup | pin_slew | pin_high_drive, 8'h00)
        @(posedge clk_sys);
        rstn <= 1'b1;
        regs = '{default: 8'h00};
        regs[9] = 8'hff;
        check_all();
        $display("second reset test done");
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        finish_test();
    end
endmodule
